// ---- verilog/dim_pkg.sv ----
// Purpose: constants and types for the drive input macro logic
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: field positions, reset values and codes used by the core
`default_nettype none
package dim_pkg;
  localparam int ADDR_W = 8;
  localparam int REF_W = 16;
  localparam int TERM_W = 5;
  localparam int TERM_ENABLE = 4;
  localparam int SETTLE_CYCLES = 3;

  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PRESET01 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRESET23 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SPEED = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h14;

  localparam int CFG_MACRO_LSB = 0;
  localparam int CFG_SRC_LSB = 8;
  localparam int CFG_KPD_WAIT_BIT = 12;
  localparam int CFG_AUTOSTART_BIT = 13;
  localparam int CFG_FMT_ONE_LSB = 16;
  localparam int CFG_FMT_TWO_LSB = 20;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [REF_W-1:0] PRESET_RESET = 16'h0000;
  localparam int CTRL_TRIP_CLEAR_BIT = 0;

  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_TRIP_BIT = 1;
  localparam int STAT_REVERSE_BIT = 2;
  localparam int STAT_FAST_BIT = 3;
  localparam int STAT_FIRE_BIT = 4;
  localparam int STAT_ARMED_BIT = 5;
  localparam int STAT_TERM_LSB = 8;
  localparam int STAT_CODE_LSB = 16;

  localparam logic [1:0] SRC_TERMINAL = 2'h0;
  localparam logic [1:0] SRC_KEYPAD = 2'h1;
  localparam logic [1:0] SRC_FIELDBUS = 2'h2;
  localparam logic [1:0] FMT_THERMISTOR = 2'h3;
  localparam logic [7:0] EXTERNAL_TRIP_CODE = 8'h01;
  localparam logic [7:0] THERMISTOR_TRIP_CODE = 8'h02;

  localparam logic [2:0] REF_ANALOG_ONE = 3'h0;
  localparam logic [2:0] REF_ANALOG_TWO = 3'h1;
  localparam logic [2:0] REF_PRESET = 3'h2;
  localparam logic [2:0] REF_KEYPAD = 3'h3;
  localparam logic [2:0] REF_FIELDBUS = 3'h4;
  localparam logic [2:0] REF_STEPPED = 3'h5;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_TRIPPED = 3'b100
  } dim_state_type;
endpackage
`default_nettype wire

// ---- verilog/dim_input_macro.sv ----
// Purpose: terminal decode into run, stop, direction, trip and speed commands
// Assumes: bus and keypad inputs synchronous to CLOCK, terminals synchronised here, APB slave with one wait-free access
// Notes: macros 18 and 19 add speed stepping and paired start
`timescale 1ns/1ns
`default_nettype none
module dim_input_macro
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dim_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] DIGITAL_IN,
  input wire logic ENABLE_IN,
  input wire logic KEYPAD_START,
  input wire logic KEYPAD_STOP,
  input wire logic FIELDBUS_START,
  input wire logic FIELDBUS_STOP,
  input wire logic [dim_pkg::REF_W-1:0] ANALOG_INPUT_ONE,
  input wire logic [dim_pkg::REF_W-1:0] ANALOG_INPUT_TWO,
  input wire logic [dim_pkg::REF_W-1:0] KEYPAD_SPEED_REFERENCE,
  input wire logic [dim_pkg::REF_W-1:0] FIELDBUS_SPEED_REFERENCE,
  output logic RUN_CMD,
  output logic REVERSE_SELECT,
  output logic FAST_STOP_ACTIVE,
  output logic TRIP_ACTIVE,
  output logic [7:0] TRIP_CODE,
  output logic FIRE_MODE,
  output logic [dim_pkg::REF_W-1:0] SPEED_REF,
  output logic [1:0] ANALOG_ONE_FORMAT,
  output logic [1:0] ANALOG_TWO_FORMAT
);
  import dim_pkg::*;

  function automatic logic pair_rise(input logic a, input logic b, input logic pa, input logic pb);
    return a & b & ~(pa & pb);
  endfunction

  function automatic logic [REF_W-1:0] sat_step(input logic [REF_W-1:0] v, input logic [REF_W-1:0] amt,
                                                input logic up);
    logic [REF_W:0] s;
    s = up ? ({1'b0, v} + {1'b0, amt}) : ({1'b0, v} - {1'b0, amt});
    if (s[REF_W])
      return up ? {REF_W{1'b1}} : {REF_W{1'b0}};
    return s[REF_W-1:0];
  endfunction

  logic [31:0] cfg_r;
  logic [REF_W-1:0] preset_r [0:3];
  logic [TERM_W-1:0] sync1_r, sync2_r, prev_r;
  logic [1:0] settle_cnt_r;
  logic settled_r, poweron_r, armed_r;
  dim_state_type state_r;
  logic reverse_r, fast_r, fire_r;
  logic [7:0] code_r;
  logic [REF_W-1:0] speed_r, step_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;

  logic [4:0] macro;
  logic [1:0] src;
  logic [TERM_W-1:0] d, p, rise, fall;
  logic lat_mode, lat_run, want_reverse, has_dir, start_ev, stop_ev, fast_ev;
  logic trip_lv, fire_lv, up_ev, dn_ev;
  logic [2:0] ref_src;
  logic [1:0] pidx;
  logic run_present, start_cond, stop_cond;
  logic [REF_W-1:0] sel_ref;
  logic apb_setup, apb_write, addr_ok, trip_clear;
  logic [31:0] rd_data;

  assign macro = cfg_r[CFG_MACRO_LSB +: 5];
  assign src = cfg_r[CFG_SRC_LSB +: 2];
  assign d = sync2_r;
  assign p = prev_r;
  // edges held off until the pipeline is full, so power-up levels are not edges
  assign rise = settled_r ? (d & ~p) : '0;
  assign fall = settled_r ? (~d & p) : '0;

  // two-stage synchroniser, then one more stage as the previous sample
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      sync1_r <= {ENABLE_IN, DIGITAL_IN};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      settle_cnt_r <= 2'h0;
      settled_r <= 1'b0;
      poweron_r <= 1'b0;
    end
    else
    begin
      poweron_r <= 1'b0;
      if (!settled_r)
      begin
        settle_cnt_r <= settle_cnt_r + 2'h1;
        if (settle_cnt_r == 2'(SETTLE_CYCLES - 1))
        begin
          settled_r <= 1'b1;
          poweron_r <= 1'b1;
        end
      end
    end
  end

  // macro decode: terminal functions per setting
  always_comb
  begin
    lat_mode = 1'b1;
    lat_run = d[0];
    want_reverse = 1'b0;
    has_dir = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    fast_ev = 1'b0;
    trip_lv = 1'b0;
    fire_lv = 1'b0;
    up_ev = 1'b0;
    dn_ev = 1'b0;
    ref_src = REF_ANALOG_ONE;
    pidx = 2'h0;
    unique case (macro)
      5'd0, 5'd6, 5'd8:
      begin
        want_reverse = d[1];
        has_dir = 1'b1;
        if (macro == 5'd0)
          ref_src = d[2] ? REF_PRESET : REF_ANALOG_ONE;
        else if (macro == 5'd6)
          trip_lv = ~d[2];
        else
        begin
          ref_src = REF_PRESET;
          pidx = {d[3], d[2]};
        end
      end
      5'd1:
      begin
        ref_src = d[1] ? REF_PRESET : REF_ANALOG_ONE;
        pidx = {1'b0, d[2]};
      end
      5'd2:
      begin
        ref_src = REF_PRESET;
        pidx = {d[2], d[1]};
      end
      5'd3:
      begin
        ref_src = d[1] ? REF_PRESET : REF_ANALOG_ONE;
        trip_lv = ~d[2];
      end
      5'd4:
        ref_src = d[1] ? REF_ANALOG_TWO : REF_ANALOG_ONE;
      5'd5, 5'd7, 5'd9:
      begin
        // both closed is the fast-stop gesture, not a run
        lat_run = d[0] ^ d[1];
        want_reverse = d[1];
        has_dir = 1'b1;
        fast_ev = settled_r & pair_rise(d[0], d[1], p[0], p[1]);
        if (macro == 5'd5)
          ref_src = d[2] ? REF_PRESET : REF_ANALOG_ONE;
        else if (macro == 5'd7)
          trip_lv = ~d[2];
        else
        begin
          ref_src = REF_PRESET;
          pidx = {d[3], d[2]};
        end
      end
      5'd10, 5'd18:
      begin
        lat_mode = 1'b0;
        start_ev = rise[0] & d[1];
        stop_ev = fall[1];
        if (macro == 5'd10)
          ref_src = d[2] ? REF_PRESET : REF_ANALOG_ONE;
        else
        begin
          up_ev = rise[2];
          dn_ev = rise[3];
          ref_src = REF_STEPPED;
        end
      end
      5'd11, 5'd13:
      begin
        lat_mode = 1'b0;
        fast_ev = settled_r & pair_rise(d[0], d[2], p[0], p[2]);
        start_ev = (rise[0] | rise[2]) & d[1] & ~fast_ev;
        want_reverse = rise[2];
        has_dir = start_ev;
        stop_ev = fall[1];
        if (macro == 5'd13)
          ref_src = d[3] ? REF_PRESET : REF_KEYPAD;
      end
      5'd12:
      begin
        fast_ev = fall[1];
        ref_src = d[2] ? REF_PRESET : REF_ANALOG_ONE;
      end
      5'd14:
      begin
        trip_lv = ~d[2];
        ref_src = REF_PRESET;
        pidx = {d[3], d[1]};
      end
      5'd15:
      begin
        ref_src = d[1] ? REF_ANALOG_ONE : REF_PRESET;
        pidx = 2'h3;
        fire_lv = d[2];
      end
      5'd16:
      begin
        ref_src = REF_PRESET;
        pidx = d[1] ? 2'h1 : 2'h3;
        fire_lv = d[2];
        want_reverse = d[3];
        has_dir = 1'b1;
      end
      5'd17:
      begin
        ref_src = REF_PRESET;
        pidx = {d[3], d[1]};
        fire_lv = d[2];
      end
      5'd19:
      begin
        lat_mode = 1'b0;
        start_ev = settled_r & pair_rise(d[0], d[2], p[0], p[2]) & d[1];
        stop_ev = fall[1];
        fast_ev = fall[3];
      end
      default:
        lat_run = 1'b0;
    endcase
  end

  // run decision per control source; stopping terms checked first
  always_comb
  begin
    run_present = (src == SRC_TERMINAL) ? (lat_mode & lat_run) : d[TERM_ENABLE];
    start_cond = 1'b0;
    stop_cond = fast_ev | ~settled_r;
    unique case (src)
      SRC_TERMINAL:
      begin
        start_cond = lat_mode ? (lat_run & armed_r) : start_ev;
        stop_cond = stop_cond | (lat_mode ? ~lat_run : (stop_ev | ~d[1]));
      end
      SRC_KEYPAD:
      begin
        start_cond = cfg_r[CFG_KPD_WAIT_BIT] ? (KEYPAD_START & d[TERM_ENABLE])
                                             : (d[TERM_ENABLE] & armed_r);
        stop_cond = stop_cond | ~d[TERM_ENABLE] | KEYPAD_STOP;
      end
      SRC_FIELDBUS:
      begin
        start_cond = FIELDBUS_START & d[TERM_ENABLE];
        stop_cond = stop_cond | ~d[TERM_ENABLE] | FIELDBUS_STOP;
      end
      default:
        stop_cond = 1'b1;
    endcase
    unique case (src == SRC_TERMINAL ? ref_src : (src == SRC_KEYPAD ? REF_KEYPAD : REF_FIELDBUS))
      REF_ANALOG_ONE: sel_ref = ANALOG_INPUT_ONE;
      REF_ANALOG_TWO: sel_ref = ANALOG_INPUT_TWO;
      REF_PRESET: sel_ref = preset_r[pidx];
      REF_KEYPAD: sel_ref = KEYPAD_SPEED_REFERENCE;
      REF_FIELDBUS: sel_ref = FIELDBUS_SPEED_REFERENCE;
      default: sel_ref = step_r;
    endcase
  end

  // a level already present at power-on only runs with autostart set
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      armed_r <= 1'b0;
    else if (poweron_r)
      armed_r <= cfg_r[CFG_AUTOSTART_BIT] | ~run_present;
    else if (settled_r && !run_present)
      armed_r <= 1'b1;
    else if (state_r == ST_RUNNING && stop_cond)
      armed_r <= 1'b0;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state_r <= ST_STOPPED;
      code_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        ST_STOPPED, ST_RUNNING:
          if (trip_lv)
          begin
            state_r <= ST_TRIPPED;
            code_r <= (cfg_r[CFG_FMT_TWO_LSB +: 2] == FMT_THERMISTOR) ? THERMISTOR_TRIP_CODE
                                                                      : EXTERNAL_TRIP_CODE;
          end
          else if (stop_cond)
            state_r <= ST_STOPPED;
          else if (start_cond)
            state_r <= ST_RUNNING;
        ST_TRIPPED:
          // clear loses while the trip contact is still open
          if (trip_clear && !trip_lv)
          begin
            state_r <= ST_STOPPED;
            code_r <= 8'h00;
          end
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      reverse_r <= 1'b0;
      fast_r <= 1'b0;
      fire_r <= 1'b0;
    end
    else
    begin
      if (src == SRC_TERMINAL && has_dir && settled_r)
        reverse_r <= want_reverse;
      if (fast_ev)
        fast_r <= 1'b1;
      else if (state_r != ST_RUNNING && start_cond && !stop_cond && !trip_lv)
        fast_r <= 1'b0;
      fire_r <= fire_lv & settled_r;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      step_r <= PRESET_RESET;
      speed_r <= PRESET_RESET;
    end
    else
    begin
      if (up_ev && !dn_ev)
        step_r <= sat_step(step_r, preset_r[0], 1'b1);
      else if (dn_ev && !up_ev)
        step_r <= sat_step(step_r, preset_r[0], 1'b0);
      speed_r <= sel_ref;
    end
  end

  // APB: ready is registered in the setup cycle, so every access has no wait state
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & pready_r & PWRITE & addr_ok;
  assign trip_clear = apb_write & (PADDR == ADDR_CONTROL) & PWDATA[CTRL_TRIP_CLEAR_BIT];

  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CONFIG: rd_data = cfg_r;
      ADDR_PRESET01: rd_data = {preset_r[1], preset_r[0]};
      ADDR_PRESET23: rd_data = {preset_r[3], preset_r[2]};
      ADDR_STATUS:
      begin
        rd_data[STAT_RUN_BIT] = (state_r == ST_RUNNING);
        rd_data[STAT_TRIP_BIT] = (state_r == ST_TRIPPED);
        rd_data[STAT_REVERSE_BIT] = reverse_r;
        rd_data[STAT_FAST_BIT] = fast_r;
        rd_data[STAT_FIRE_BIT] = fire_r;
        rd_data[STAT_ARMED_BIT] = armed_r;
        rd_data[STAT_TERM_LSB +: TERM_W] = d;
        rd_data[STAT_CODE_LSB +: 8] = code_r;
      end
      ADDR_SPEED: rd_data = {16'h0000, speed_r};
      ADDR_CONTROL: rd_data = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup & ~addr_ok;
      prdata_r <= (apb_setup && !PWRITE) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cfg_r <= CFG_RESET;
      for (int i = 0; i < 4; i++)
        preset_r[i] <= PRESET_RESET;
    end
    else if (apb_write)
    begin
      if (PADDR == ADDR_CONFIG)
        cfg_r <= PWDATA;
      if (PADDR == ADDR_PRESET01)
      begin
        preset_r[0] <= PWDATA[15:0];
        preset_r[1] <= PWDATA[31:16];
      end
      if (PADDR == ADDR_PRESET23)
      begin
        preset_r[2] <= PWDATA[15:0];
        preset_r[3] <= PWDATA[31:16];
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign RUN_CMD = (state_r == ST_RUNNING);
  assign REVERSE_SELECT = reverse_r;
  assign FAST_STOP_ACTIVE = fast_r;
  assign TRIP_ACTIVE = (state_r == ST_TRIPPED);
  assign TRIP_CODE = code_r;
  assign FIRE_MODE = fire_r;
  assign SPEED_REF = speed_r;
  assign ANALOG_ONE_FORMAT = cfg_r[CFG_FMT_ONE_LSB +: 2];
  assign ANALOG_TWO_FORMAT = cfg_r[CFG_FMT_TWO_LSB +: 2];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  chk_trip_entry: assert property (trip_lv && state_r != ST_TRIPPED |=> state_r == ST_TRIPPED)
    else $error("external trip did not trip the drive");
  chk_latched_stop: assert property (src == SRC_TERMINAL && lat_mode && !lat_run |=> !RUN_CMD)
    else $error("open latched contact left the drive running");
  chk_stop_wins: assert property (start_cond && stop_cond && state_r == ST_STOPPED |=> !RUN_CMD)
    else $error("start won over a coincident stop");
  chk_bus_enable: assert property (src == SRC_FIELDBUS && !d[TERM_ENABLE] |=> !RUN_CMD)
    else $error("fieldbus start without hardware enable");
  chk_fast_flag: assert property (fast_ev |=> FAST_STOP_ACTIVE && !RUN_CMD)
    else $error("fast stop not flagged");
  chk_nc_stop: assert property (src == SRC_TERMINAL && !lat_mode && !d[1] |=> !RUN_CMD)
    else $error("momentary start accepted with stop open");
  chk_step_up: assert property (up_ev && !dn_ev |=> step_r == sat_step($past(step_r), $past(preset_r[0]), 1'b1))
    else $error("speed step up wrong");
  chk_dir_follow: assert property (src == SRC_TERMINAL && has_dir && settled_r |=> REVERSE_SELECT == $past(want_reverse))
    else $error("direction did not follow its terminal");
  chk_ref_source: assert property (settled_r |=> SPEED_REF == $past(sel_ref))
    else $error("speed reference not taken from selected source");
  chk_apb_answer: assert property (apb_setup |=> PREADY ##1 !PREADY)
    else $error("register access not answered in one cycle");

  cov_run_start: cover property (state_r == ST_STOPPED ##1 state_r == ST_RUNNING);
  cov_trip: cover property (state_r == ST_RUNNING ##1 state_r == ST_TRIPPED);
  cov_fast_stop: cover property (RUN_CMD && fast_ev);
  cov_bus_start: cover property (src == SRC_FIELDBUS && FIELDBUS_START && !RUN_CMD ##1 RUN_CMD);
endmodule
`default_nettype wire

// ---- test/dim_contacts.sv ----
// Purpose: contacts and switches wired to the control terminals
// Assumes: a closed contact reads high, bit 4 of want is the enable
// Notes: slow mode models a sluggish relay, two cycles later
`timescale 1ns/1ns
`default_nettype none
module dim_contacts
(
  input wire logic CLOCK,
  input wire logic [4:0] want,
  input wire logic slow,
  output logic [3:0] digital_in,
  output logic enable_in
);
  logic [4:0] d1_r = 5'h00;
  logic [4:0] d2_r = 5'h00;
  always @(posedge CLOCK)
  begin
    d1_r <= want;
    d2_r <= d1_r;
  end
  // all contacts move together so a paired gesture is never split
  assign {enable_in, digital_in} = slow ? d2_r : d1_r;
endmodule
`default_nettype wire

// ---- test/dim_input_macro_test.sv ----
// Purpose: self-checking bench for the drive input macro logic
// Assumes: contacts read high when closed, APB answers within a few cycles
// Notes: contact delay is random, so each contact change waits eight cycles
`timescale 1ns/1ns
`default_nettype none
module dim_input_macro_test;
  import dim_pkg::*;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, ENABLE_IN;
  logic [3:0] DIGITAL_IN;
  logic KEYPAD_START = 1'b0;
  logic KEYPAD_STOP = 1'b0;
  logic FIELDBUS_START = 1'b0;
  logic FIELDBUS_STOP = 1'b0;
  logic [REF_W-1:0] ai1 = 16'h0000;
  logic [REF_W-1:0] ai2 = 16'h0000;
  logic [REF_W-1:0] kref = 16'h0000;
  logic [REF_W-1:0] fref = 16'h0000;
  logic RUN_CMD, REVERSE_SELECT, FAST_STOP_ACTIVE, TRIP_ACTIVE, FIRE_MODE;
  logic [7:0] TRIP_CODE;
  logic [REF_W-1:0] SPEED_REF;
  logic [1:0] ANALOG_ONE_FORMAT, ANALOG_TWO_FORMAT;
  logic [4:0] want = 5'h00;
  logic slow = 1'b0;
  logic [31:0] seed = 32'h0000_f102;
  logic [31:0] q, r;
  logic err;
  logic [REF_W-1:0] p0, base;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  always #25 CLOCK = ~CLOCK;

  dim_contacts contacts (.CLOCK(CLOCK), .want(want), .slow(slow), .digital_in(DIGITAL_IN),
    .enable_in(ENABLE_IN));

  dim_input_macro dut (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DIGITAL_IN(DIGITAL_IN), .ENABLE_IN(ENABLE_IN), .KEYPAD_START(KEYPAD_START),
    .KEYPAD_STOP(KEYPAD_STOP), .FIELDBUS_START(FIELDBUS_START), .FIELDBUS_STOP(FIELDBUS_STOP),
    .ANALOG_INPUT_ONE(ai1), .ANALOG_INPUT_TWO(ai2), .KEYPAD_SPEED_REFERENCE(kref),
    .FIELDBUS_SPEED_REFERENCE(fref), .RUN_CMD(RUN_CMD), .REVERSE_SELECT(REVERSE_SELECT),
    .FAST_STOP_ACTIVE(FAST_STOP_ACTIVE), .TRIP_ACTIVE(TRIP_ACTIVE), .TRIP_CODE(TRIP_CODE),
    .FIRE_MODE(FIRE_MODE), .SPEED_REF(SPEED_REF), .ANALOG_ONE_FORMAT(ANALOG_ONE_FORMAT),
    .ANALOG_TWO_FORMAT(ANALOG_TWO_FORMAT));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge CLOCK);
    end
    if (n == 20)
      n_mismatch++;
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge, so a following call never drives psel twice in one step
    @(posedge CLOCK);
  endtask

  task automatic set_c(input logic [4:0] v);
    slow <= seed[3];
    want <= v;
    repeat (8) @(posedge CLOCK);
  endtask

  task automatic cfg(input logic [4:0] m, input logic [1:0] s, input logic [31:0] extra);
    apb(1'b1, ADDR_CONFIG, 32'(m) | (32'(s) << CFG_SRC_LSB) | extra);
    repeat (2) @(posedge CLOCK);
  endtask

  task automatic st(input logic run, input logic reverse_select);
    check(32'(RUN_CMD), 32'(run));
    check(32'(REVERSE_SELECT), 32'(reverse_select));
  endtask

  // one-cycle key or command pulse: keypad start, keypad stop, bus start, bus stop
  task automatic kick(input logic [3:0] k);
    {KEYPAD_START, KEYPAD_STOP, FIELDBUS_START, FIELDBUS_STOP} <= k;
    @(posedge CLOCK);
    {KEYPAD_START, KEYPAD_STOP, FIELDBUS_START, FIELDBUS_STOP} <= 4'h0;
    repeat (6) @(posedge CLOCK);
  endtask

  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    seed = xs(seed);
    // small step keeps the stepped reference clear of saturation
    p0 = {4'h0, seed[11:0]};
    seed = xs(seed);
    {kref, fref} <= seed;
    repeat (12) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check(q, CFG_RESET);
    check(32'(err), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, ADDR_PRESET01, {16'h0000, p0});
    apb(1'b0, ADDR_PRESET01, 32'h0);
    check(q, {16'h0000, p0});
    cfg(5'h00, SRC_TERMINAL, 32'h0);
    set_c(5'h11);
    st(1'b1, 1'b0);
    set_c(5'h13);
    st(1'b1, 1'b1);
    set_c(5'h10);
    st(1'b0, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      r = seed;
      ai1 <= r[15:0];
      set_c({2'b10, r[17], 2'b01});
      check(32'(SPEED_REF), r[17] ? 32'(p0) : 32'(r[15:0]));
    end
    set_c(5'h10);
    cfg(5'h05, SRC_TERMINAL, 32'h0);
    set_c(5'h12);
    st(1'b1, 1'b1);
    set_c(5'h10);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h11);
    st(1'b1, 1'b0);
    set_c(5'h10);
    cfg(5'h09, SRC_TERMINAL, 32'h0);
    set_c(5'h12);
    set_c(5'h16);
    st(1'b1, 1'b1);
    set_c(5'h12);
    st(1'b1, 1'b1);
    set_c(5'h13);
    st(1'b0, 1'b1);
    check(32'(FAST_STOP_ACTIVE), 32'h1);
    set_c(5'h12);
    set_c(5'h17);
    check(32'(RUN_CMD), 32'h0);
    check(32'(FAST_STOP_ACTIVE), 32'h1);
    set_c(5'h10);
    cfg(5'h13, SRC_TERMINAL, 32'h0);
    set_c(5'h1a);
    set_c(5'h1f);
    check(32'(RUN_CMD), 32'h1);
    set_c(5'h17);
    check(32'(RUN_CMD), 32'h0);
    check(32'(FAST_STOP_ACTIVE), 32'h1);
    set_c(5'h1a);
    set_c(5'h1f);
    check(32'(FAST_STOP_ACTIVE), 32'h0);
    set_c(5'h1d);
    set_c(5'h1f);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h1a);
    set_c(5'h1d);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h10);
    cfg(5'h12, SRC_TERMINAL, 32'h0);
    set_c(5'h12);
    set_c(5'h13);
    set_c(5'h12);
    check(32'(RUN_CMD), 32'h1);
    apb(1'b0, ADDR_SPEED, 32'h0);
    base = q[15:0];
    repeat (2)
    begin
      set_c(5'h16);
      set_c(5'h12);
    end
    apb(1'b0, ADDR_SPEED, 32'h0);
    check(q, {16'h0000, base + p0 + p0});
    set_c(5'h1a);
    set_c(5'h12);
    check(32'(SPEED_REF), 32'(base + p0));
    set_c(5'h10);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h11);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h10);
    cfg(5'h0b, SRC_TERMINAL, 32'h0);
    set_c(5'h12);
    set_c(5'h16);
    st(1'b1, 1'b1);
    set_c(5'h12);
    st(1'b1, 1'b1);
    set_c(5'h13);
    st(1'b1, 1'b0);
    set_c(5'h10);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h12);
    set_c(5'h17);
    check(32'(RUN_CMD), 32'h0);
    check(32'(FAST_STOP_ACTIVE), 32'h1);
    set_c(5'h10);
    cfg(5'h0f, SRC_TERMINAL, 32'h0);
    set_c(5'h14);
    check(32'(FIRE_MODE), 32'h1);
    set_c(5'h10);
    check(32'(FIRE_MODE), 32'h0);
    cfg(5'h03, SRC_TERMINAL, 32'(2'h1) << CFG_FMT_ONE_LSB);
    for (int f = 0; f < 2; f++)
    begin
      set_c(5'h14);
      set_c(5'h10);
      set_c(5'h14);
      check(32'(TRIP_ACTIVE), 32'h1);
      check(32'(TRIP_CODE), f ? 32'(THERMISTOR_TRIP_CODE) : 32'(EXTERNAL_TRIP_CODE));
      apb(1'b1, ADDR_CONTROL, 32'h1 << CTRL_TRIP_CLEAR_BIT);
      repeat (4) @(posedge CLOCK);
      check(32'(TRIP_ACTIVE), 32'h0);
      cfg(5'h03, SRC_TERMINAL, (32'(2'h1) << CFG_FMT_ONE_LSB) | (32'(FMT_THERMISTOR) << CFG_FMT_TWO_LSB));
    end
    check(32'(ANALOG_ONE_FORMAT), 32'h1);
    check(32'(ANALOG_TWO_FORMAT), 32'(FMT_THERMISTOR));
    cfg(5'h00, SRC_FIELDBUS, 32'h0);
    set_c(5'h00);
    kick(4'h2);
    check(32'(RUN_CMD), 32'h0);
    set_c(5'h10);
    kick(4'h2);
    check(32'(RUN_CMD), 32'h1);
    check(32'(SPEED_REF), 32'(fref));
    kick(4'h1);
    cfg(5'h00, SRC_KEYPAD, 32'h1 << CFG_KPD_WAIT_BIT);
    set_c(5'h00);
    set_c(5'h10);
    check(32'(RUN_CMD), 32'h0);
    kick(4'h8);
    check(32'(RUN_CMD), 32'h1);
    check(32'(SPEED_REF), 32'(kref));
    kick(4'h4);
    check(32'(RUN_CMD), 32'h0);
    cfg(5'h00, SRC_KEYPAD, 32'h0);
    set_c(5'h00);
    set_c(5'h10);
    check(32'(RUN_CMD), 32'h1);
    // reset with the run contact already closed and autostart clear
    set_c(5'h11);
    SRST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (8) @(posedge CLOCK);
    check(32'(RUN_CMD), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(32'(q[STAT_ARMED_BIT]), 32'h0);
    set_c(5'h10);
    set_c(5'h11);
    check(32'(RUN_CMD), 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
